//--- pipe_ctrl.sv
// Purpose: fetch and execute pipeline control with branch prediction
// Assumes: local memories return read data in the cycle after the strobe
// Notes: one core clock; the bus rate is an enable from a divider
// Operation
// - core clock is a whole multiple of the bus clock rate.
// - fetch runs address, fetch start, fetch end, early decode in order.
// - a ten-entry queue lets fetch run ahead of execution.
// - execute has decode, address, two operand fetch and compute phases.
// - stores present data, then commit; other instructions skip both.
// - two decode registers fill from the queue or straight from decode.
// - eight-entry direct-mapped branch cache with two-bit state.
// - branch cache hit taken redirects fetch from the fetch start phase.
// - correctly predicted taken cached branches take zero cycles when a valid non-branch op follows in decode.
// - cache misses use a 128-entry two-bit prediction table.
// - early decode computes taken targets without cache and redirects.
// - unconditional branches and calls redirect fetch ahead of execution.
// - four-entry return stack; calls push, returns pop their target.
// - address or execute unit chosen from current pipeline state.
// - common ops run in the address unit and forward without stalls.
// - a move folds with a neighbouring ALU, move, load or store op; both issue in one cycle.
// - invalid op words raise the illegal exception with vector four.
// - three-stage multiply pipe; 16x16 accumulate issues every cycle.
// - a 32x32 multiply-accumulate holds off the next issue three cycles.
// - divide offers 32/16, 32/32 quotient and 32/32 remainder.
// - instruction and operand memories use separate buses.
// - most instructions, all loads and stores, take one cycle.
`timescale 1ns/100ps
module pipe_ctrl #(
  parameter int unsigned BUS_RATIO = pipe_pkg::BUS_RATIO_DEF,
  parameter int unsigned QDEPTH = pipe_pkg::QDEPTH_DEF,
  parameter logic [31:0] RESET_PC = pipe_pkg::RESET_PC_DEF,
  parameter logic [31:0] EXC_PC = pipe_pkg::EXC_PC_DEF
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  output logic BUS_TICK_O,
  output logic IFETCH_REQ_O,
  output logic [31:0] IFETCH_ADDR_O,
  input wire logic [15:0] IFETCH_DATA_I,
  output logic OPND_RD_O,
  output logic [31:0] OPND_RADDR_O,
  input wire logic [31:0] OPND_RDATA_I,
  output logic OPND_WE_O,
  output logic [31:0] OPND_WADDR_O,
  output logic [31:0] OPND_WDATA_O,
  input wire logic [31:0] BASE_ADDR_I,
  input wire logic [31:0] REG_OPND_I,
  input wire logic [31:0] STORE_DATA_I,
  input wire logic COND_TRUE_I,
  output logic [1:0] ISSUE_CNT_O,
  output logic ISSUE_AALU_O,
  output logic BR_FOLD_O,
  output logic MISPREDICT_O,
  output logic ILLEGAL_O,
  output logic [7:0] EXC_VECTOR_O,
  output logic [31:0] ACC_O,
  output logic [31:0] DIV_Q_O,
  output logic [31:0] DIV_R_O
);
  import pipe_pkg::*;

  localparam int unsigned QW = $clog2(QDEPTH + 1);

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic bus_tick;
    logic [31:0] fa_pc;
    logic f1_v;
    logic [31:0] f1_pc;
    instr_s f2;
    instr_s ed;
    instr_s [QDEPTH-1:0] q;
    logic [QW-1:0] qh;
    logic [QW-1:0] qt;
    logic [QW-1:0] qn;
    instr_s [1:0] ds;
    op_s oa;
    op_s of1;
    op_s of2;
    op_s cx;
    op_s wv;
    op_s mc;
    logic [BC_ENTRIES-1:0] bc_v;
    logic [BC_ENTRIES-1:0][31:0] bc_tag;
    logic [BC_ENTRIES-1:0][31:0] bc_tgt;
    logic [BC_ENTRIES-1:0][1:0] bc_st;
    logic [PHT_ENTRIES-1:0][1:0] pht;
    logic [RS_ENTRIES-1:0][31:0] rs;
    logic [1:0] hold;
    logic [1:0] issue_cnt;
    logic aalu;
    logic fold;
    logic mispred;
    logic illegal;
    logic [7:0] vec;
    logic rd;
    logic [31:0] raddr;
    logic we;
    logic [31:0] waddr;
    logic [31:0] wdata;
  } st_s;

  st_s r, n;
  opclass_e c0, c1, ce, ci;
  instr_s d0, d1, edo, iss_i;
  logic act, flush, iss_v, mate, ed_redir, hit, ptk, can, used, push;
  logic [31:0] fix_pc, ed_tgt;
  logic [1:0] take;
  logic [QW-1:0] pop;
  logic [BC_IW-1:0] bi, bj;
  logic [PHT_IW-1:0] pj;
  xreq_s xreq;

  function automatic logic [QW-1:0] qidx(input logic [QW-1:0] h,
                                         input logic [QW-1:0] k);
    logic [QW:0] s;
    s = {1'b0, h} + {1'b0, k};
    if (s >= (QW+1)'(QDEPTH)) begin
      s = s - (QW+1)'(QDEPTH);
    end
    return s[QW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    d0 = r.ds[0];
    d1 = r.ds[1];
    c0 = classify(d0.word);
    c1 = classify(d1.word);
    ce = classify(r.ed.word);
    act = 1'b0;
    flush = 1'b0;
    fix_pc = r.fa_pc;
    iss_v = 1'b0;
    iss_i = d0;
    mate = 1'b0;
    take = 2'h0;
    bj = bc_idx(d0.pc);
    pj = pht_idx(d0.pc);
    n.bus_tick = 1'b0;
    n.fold = 1'b0;
    n.mispred = 1'b0;
    n.illegal = 1'b0;
    n.vec = '0;

    // bus rate enable; local memories stay on the core clock
    if (r.div_cnt == DIV_W'(BUS_RATIO - 1)) begin
      n.div_cnt = '0;
      n.bus_tick = 1'b1;
    end else begin
      n.div_cnt = r.div_cnt + DIV_W'(1);
    end

    ////////////////////////////////////////////////////////////////////
    // dual decode: resolve branches, fold, issue
    if (r.hold != 2'h0) begin
      n.hold = r.hold - 2'h1;
    end
    if (d0.v && r.hold == 2'h0) begin
      if (c0 == C_ILL) begin
        n.illegal = 1'b1;
        n.vec = ILLEGAL_VEC;
        flush = 1'b1;
        fix_pc = EXC_PC;
      end else if (is_branch(c0)) begin
        act = (c0 == C_BCC) ? COND_TRUE_I : 1'b1;
        if (c0 == C_BCC) begin
          if (d0.bc_hit) begin
            n.bc_st[bj] = sat_upd(r.bc_st[bj], act);
          end else begin
            n.pht[pj] = sat_upd(r.pht[pj], act);
            if (act) begin
              n.bc_v[bj] = 1'b1;
              n.bc_tag[bj] = d0.pc;
              n.bc_tgt[bj] = br_target(d0.pc, d0.word);
              n.bc_st[bj] = PRED_WT;
            end
          end
        end
        if (act != d0.pred) begin
          flush = 1'b1;
          n.mispred = 1'b1;
          fix_pc = act ? br_target(d0.pc, d0.word) : d0.pc + OPW_BYTES;
        end else if (d0.bc_hit && act && d1.v && !is_branch(c1) &&
                     c1 != C_ILL) begin
          // branch rides along with its successor at no cost
          iss_v = 1'b1;
          iss_i = d1;
          take = 2'h2;
          n.fold = 1'b1;
        end else begin
          take = 2'h1;
        end
      end else begin
        iss_v = 1'b1;
        take = 2'h1;
        if (d1.v && simple(c0) && simple(c1) &&
            (c0 == C_MOVE || c1 == C_MOVE)) begin
          mate = 1'b1;
          take = 2'h2;
        end
      end
    end
    n.issue_cnt = flush ? 2'h0 : take;

    ////////////////////////////////////////////////////////////////////
    // execute pipeline; every phase advances every cycle
    ci = classify(iss_i.word);
    n.oa = '0;
    if (iss_v) begin
      n.oa.v = 1'b1;
      n.oa.cls = ci;
      n.oa.word = iss_i.word;
      n.oa.mate = mate;
      // execute unit busy with a load, multiply or divide operand: run in the address unit
      n.oa.aalu = simple(ci) && !uses_mem(ci) && r.oa.v &&
        uses_mem(r.oa.cls);
      if (ci == C_MAC32) begin
        n.hold = MAC32_GAP - 2'h1;
      end
    end
    n.aalu = n.oa.aalu;
    n.of1 = r.oa;
    n.of1.addr = BASE_ADDR_I + sext8(r.oa.word[7:0]);
    n.rd = r.oa.v && uses_mem(r.oa.cls);
    n.raddr = n.of1.addr;
    n.of2 = r.of1;
    n.cx = r.of2;
    if (r.of2.v && uses_mem(r.of2.cls)) begin
      n.cx.data = OPND_RDATA_I;
    end
    xreq.start = r.cx.v;
    xreq.cls = r.cx.cls;
    xreq.dk = div_e'(r.cx.word[1:0]);
    xreq.a = r.cx.cls == C_DIV ? REG_OPND_I : r.cx.data;
    xreq.b = r.cx.cls == C_DIV ? r.cx.data : REG_OPND_I;
    n.wv = '0;
    if (r.cx.v && r.cx.cls == C_STORE) begin
      n.wv = r.cx;
      n.wv.data = STORE_DATA_I;
    end
    n.wdata = n.wv.v ? n.wv.data : r.wdata;
    n.mc = r.wv;
    n.we = r.wv.v;
    n.waddr = r.wv.addr;

    ////////////////////////////////////////////////////////////////////
    // early decode: second-level prediction, calls, returns
    edo = r.ed;
    ed_redir = 1'b0;
    ed_tgt = br_target(r.ed.pc, r.ed.word);
    if (r.ed.v && !flush) begin
      case (ce)
        C_BCC: begin
          if (!r.ed.bc_hit) begin
            edo.pred = r.pht[pht_idx(r.ed.pc)][1];
            ed_redir = edo.pred;
          end
        end
        C_BRA, C_JSR: begin
          edo.pred = 1'b1;
          ed_redir = 1'b1;
          if (ce == C_JSR) begin
            for (int k = RS_ENTRIES - 1; k > 0; k--) begin
              n.rs[k] = r.rs[k-1];
            end
            n.rs[0] = r.ed.pc + OPW_BYTES;
          end
        end
        C_RTS: begin
          edo.pred = 1'b1;
          ed_redir = 1'b1;
          ed_tgt = r.rs[0];
          for (int k = 0; k < RS_ENTRIES - 1; k++) begin
            n.rs[k] = r.rs[k+1];
          end
        end
        default: begin
          edo.pred = r.ed.pred;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////
    // decode refill from the queue, else straight from early decode
    pop = '0;
    used = 1'b0;
    push = 1'b0;
    case (take)
      2'h1: begin
        n.ds[0] = r.ds[1];
        n.ds[1] = '0;
      end
      2'h2: begin
        n.ds = '0;
      end
      default: begin
        n.ds = r.ds;
      end
    endcase
    for (int k = 0; k < 2; k++) begin
      if (!n.ds[k].v) begin
        if (r.qn > pop) begin
          n.ds[k] = r.q[qidx(r.qh, pop)];
          pop = pop + QW'(1);
        end else if (edo.v && !used) begin
          n.ds[k] = edo;
          used = 1'b1;
        end
      end
    end
    if (edo.v && !used) begin
      n.q[r.qt] = edo;
      push = 1'b1;
    end
    n.qh = qidx(r.qh, pop);
    n.qt = qidx(r.qt, QW'(push));
    n.qn = r.qn - pop + QW'(push);

    ////////////////////////////////////////////////////////////////////
    // fetch phases: address, start, completion
    bi = bc_idx(r.f1_pc);
    hit = r.f1_v && r.bc_v[bi] && r.bc_tag[bi] == r.f1_pc;
    ptk = hit && r.bc_st[bi][1];
    // leave room for every word already in flight
    can = r.qn <= QW'(QDEPTH - FETCH_INFLIGHT);
    n.f2.v = r.f1_v;
    n.f2.pc = r.f1_pc;
    n.f2.word = '0;
    n.f2.bc_hit = hit;
    n.f2.pred = ptk;
    n.ed = r.f2;
    n.ed.word = IFETCH_DATA_I;
    if (ed_redir) begin
      n.f1_v = 1'b0;
      n.f2 = '0;
      n.ed = '0;
      n.fa_pc = ed_tgt;
    end else if (ptk) begin
      n.f1_v = 1'b0;
      n.fa_pc = r.bc_tgt[bi];
    end else if (can) begin
      n.f1_v = 1'b1;
      n.f1_pc = r.fa_pc;
      n.fa_pc = r.fa_pc + OPW_BYTES;
    end else begin
      n.f1_v = 1'b0;
    end

    // wrong-path work dies; return stack is not repaired
    if (flush) begin
      n.f1_v = 1'b0;
      n.f2 = '0;
      n.ed = '0;
      n.ds = '0;
      n.qh = '0;
      n.qt = '0;
      n.qn = '0;
      n.fa_pc = fix_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      r <= '0;
      r.fa_pc <= RESET_PC;
    end else begin
      r <= n;
    end
  end

  mac_div_unit u_mac_div (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .req_i(xreq),
    .acc_o(ACC_O),
    .quo_o(DIV_Q_O),
    .rem_o(DIV_R_O)
  );

  assign BUS_TICK_O = r.bus_tick;
  assign IFETCH_REQ_O = r.f1_v;
  assign IFETCH_ADDR_O = r.f1_pc;
  assign OPND_RD_O = r.rd;
  assign OPND_RADDR_O = r.raddr;
  assign OPND_WE_O = r.we;
  assign OPND_WADDR_O = r.waddr;
  assign OPND_WDATA_O = r.wdata;
  assign ISSUE_CNT_O = r.issue_cnt;
  assign ISSUE_AALU_O = r.aalu;
  assign BR_FOLD_O = r.fold;
  assign MISPREDICT_O = r.mispred;
  assign ILLEGAL_O = r.illegal;
  assign EXC_VECTOR_O = r.vec;
endmodule // pipe_ctrl

//--- pipe_pkg.sv
// Purpose: shared constants, types and helpers of the core pipeline control
// Assumes: one core clock; every instruction is one 16-bit operation word
// Notes: opcode classes are a compact internal encoding of the op word
package pipe_pkg;
  localparam int unsigned BUS_RATIO_DEF = 4;
  localparam int unsigned QDEPTH_DEF = 10;
  localparam int unsigned BC_ENTRIES = 8;
  localparam int unsigned BC_IW = 3;
  localparam int unsigned PHT_ENTRIES = 128;
  localparam int unsigned PHT_IW = 7;
  localparam int unsigned IDX_LSB = 1;
  localparam int unsigned RS_ENTRIES = 4;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned FETCH_INFLIGHT = 4;
  localparam logic [1:0] MAC32_GAP = 2'h3;
  localparam logic [7:0] ILLEGAL_VEC = 8'h04;
  localparam logic [31:0] RESET_PC_DEF = 32'h0000_0000;
  localparam logic [31:0] EXC_PC_DEF = 32'h0000_0400;
  localparam logic [31:0] OPW_BYTES = 32'h0000_0002;
  localparam logic [1:0] PRED_WT = 2'h2;
  localparam logic [1:0] PRED_ST = 2'h3;
  localparam logic [1:0] PRED_SN = 2'h0;
  localparam logic [1:0] DK_BAD = 2'h3;

  typedef enum logic [3:0] {
    C_ALU = 4'h0, C_MOVE = 4'h1, C_LOAD = 4'h2, C_STORE = 4'h3,
    C_BCC = 4'h4, C_BRA = 4'h5, C_JSR = 4'h6, C_RTS = 4'h7,
    C_MAC16 = 4'h8, C_MAC32 = 4'h9, C_DIV = 4'ha, C_ILL = 4'hf
  } opclass_e;

  typedef enum logic [1:0] {
    DV_32_16 = 2'h0, DV_Q32 = 2'h1, DV_R32 = 2'h2, DV_NONE = 2'h3
  } div_e;

  typedef struct packed {
    logic v;
    logic [31:0] pc;
    logic [15:0] word;
    logic bc_hit;
    logic pred;
  } instr_s;

  typedef struct packed {
    logic v;
    opclass_e cls;
    logic [15:0] word;
    logic aalu;
    logic mate;
    logic [31:0] addr;
    logic [31:0] data;
  } op_s;

  typedef struct packed {
    logic start;
    opclass_e cls;
    div_e dk;
    logic [31:0] a;
    logic [31:0] b;
  } xreq_s;

  function automatic opclass_e classify(input logic [15:0] w);
    if (w[15:12] == 4'ha && w[1:0] == DK_BAD) return C_ILL;
    if (w[15:12] > 4'ha) return C_ILL;
    return opclass_e'(w[15:12]);
  endfunction

  function automatic logic is_branch(input opclass_e c);
    return c == C_BCC || c == C_BRA || c == C_JSR || c == C_RTS;
  endfunction

  function automatic logic simple(input opclass_e c);
    return c == C_ALU || c == C_MOVE || c == C_LOAD || c == C_STORE;
  endfunction

  function automatic logic uses_mem(input opclass_e c);
    return c == C_LOAD || c == C_MAC16 || c == C_MAC32 || c == C_DIV;
  endfunction

  function automatic logic [31:0] sext8(input logic [7:0] d);
    return {{24{d[7]}}, d};
  endfunction

  function automatic logic [31:0] br_target(input logic [31:0] pc,
                                            input logic [15:0] w);
    return pc + OPW_BYTES + sext8(w[7:0]);
  endfunction

  function automatic logic [1:0] sat_upd(input logic [1:0] s,
                                         input logic t);
    if (t) return (s == PRED_ST) ? s : s + 2'h1;
    return (s == PRED_SN) ? s : s - 2'h1;
  endfunction

  function automatic logic [BC_IW-1:0] bc_idx(input logic [31:0] pc);
    return pc[IDX_LSB +: BC_IW];
  endfunction

  function automatic logic [PHT_IW-1:0] pht_idx(input logic [31:0] pc);
    return pc[IDX_LSB +: PHT_IW];
  endfunction
endpackage

//--- mac_div_unit.sv
// Purpose: three-stage multiply-accumulate pipe and integer divider
// Assumes: a start pulse carries both operands in the same cycle
// Notes: divide by zero leaves the previous results untouched
`timescale 1ns/100ps
module mac_div_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input pipe_pkg::xreq_s req_i,
  output logic [31:0] acc_o,
  output logic [31:0] quo_o,
  output logic [31:0] rem_o
);
  import pipe_pkg::*;

  typedef struct packed {
    logic s1_v;
    logic s1_wide;
    logic [31:0] s1_a;
    logic [31:0] s1_b;
    logic s2_v;
    logic [31:0] s2_p;
    logic [31:0] acc;
    logic [31:0] quo;
    logic [31:0] rem;
  } mst_s;

  mst_s r, n;

  always_comb begin
    n = r;
    // stage 1 operands, stage 2 product, stage 3 accumulate
    n.s1_v = req_i.start && (req_i.cls == C_MAC16 || req_i.cls == C_MAC32);
    n.s1_wide = req_i.cls == C_MAC32;
    n.s1_a = req_i.a;
    n.s1_b = req_i.b;
    n.s2_v = r.s1_v;
    n.s2_p = r.s1_wide ? 32'(r.s1_a * r.s1_b) :
      32'(r.s1_a[15:0]) * 32'(r.s1_b[15:0]);
    if (r.s2_v) begin
      n.acc = r.acc + r.s2_p;
    end
    if (req_i.start && req_i.cls == C_DIV) begin
      case (req_i.dk)
        DV_32_16: begin
          if (req_i.b[15:0] != 16'h0) begin
            n.quo = {16'h0, 16'(req_i.a / {16'h0, req_i.b[15:0]})};
            n.rem = {16'h0, 16'(req_i.a % {16'h0, req_i.b[15:0]})};
          end
        end
        DV_Q32: begin
          if (req_i.b != 32'h0) begin
            n.quo = req_i.a / req_i.b;
          end
        end
        DV_R32: begin
          if (req_i.b != 32'h0) begin
            n.rem = req_i.a % req_i.b;
          end
        end
        default: begin
          n.quo = r.quo;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign acc_o = r.acc;
  assign quo_o = r.quo;
  assign rem_o = r.rem;
endmodule // mac_div_unit

//--- mem_model.sv
// Purpose: local instruction and operand memories facing pipe_ctrl
// Assumes: reads answer in the cycle after the strobe, no wait states
// Notes: an idle read bus shows the inverse of its last value
`timescale 1ns/100ps
module mem_model (
  input wire logic clk_i,
  input wire logic ireq_i,
  input wire logic [31:0] iaddr_i,
  output logic [15:0] idata_o,
  input wire logic rd_i,
  input wire logic [31:0] raddr_i,
  output logic [31:0] rdata_o,
  input wire logic we_i,
  input wire logic [31:0] waddr_i,
  input wire logic [31:0] wdata_i
);
  logic [15:0] imem [0:1023];
  logic [31:0] dmem [0:15];

  initial begin
    idata_o = 16'h0000;
    rdata_o = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // separate buses, so a fetch and an operand access never wait
  always @(posedge clk_i) begin
    idata_o <= ireq_i ? imem[iaddr_i[10:1]] : ~idata_o;
    rdata_o <= rd_i ? dmem[raddr_i[5:2]] : ~rdata_o;
    if (we_i) begin
      dmem[waddr_i[5:2]] <= wdata_i;
    end
  end
endmodule // mem_model

//--- pipe_ctrl_sva.sv
// Purpose: port-level checks of pipe_ctrl
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every pipe_ctrl instance
`timescale 1ns/100ps
module pipe_ctrl_sva
  import pipe_pkg::*;
#(
  parameter int unsigned BUS_RATIO = BUS_RATIO_DEF,
  parameter logic [31:0] RESET_PC = RESET_PC_DEF
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic BUS_TICK_O,
  input wire logic IFETCH_REQ_O,
  input wire logic [31:0] IFETCH_ADDR_O,
  input wire logic OPND_WE_O,
  input wire logic [31:0] OPND_WDATA_O,
  input wire logic [1:0] ISSUE_CNT_O,
  input wire logic MISPREDICT_O,
  input wire logic ILLEGAL_O,
  input wire logic [7:0] EXC_VECTOR_O
);
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  logic seen_r;
  logic seen_nxt;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);

  ////////////////////////////////////////////////////////////////////////
  // cycles since the last bus tick; only judged once a tick was seen
  always_comb begin
    gap_nxt = BUS_TICK_O ? 8'h00 : gap_r + 8'h01;
    seen_nxt = seen_r | BUS_TICK_O;
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_tick_period: assert property (
    seen_r |-> BUS_TICK_O == (gap_r == 8'(BUS_RATIO - 1)))
    else $error("bus tick spacing wrong");
  chk_first_fetch: assert property (
    $fell(RESET_I) |-> !IFETCH_REQ_O ##[1:2]
      (IFETCH_REQ_O && IFETCH_ADDR_O == RESET_PC))
    else $error("first fetch late or misplaced");
  chk_fetch_aligned: assert property (
    IFETCH_REQ_O |-> !IFETCH_ADDR_O[0])
    else $error("odd fetch address");
  chk_vector_value: assert property (
    EXC_VECTOR_O == (ILLEGAL_O ? ILLEGAL_VEC : 8'h00))
    else $error("exception vector wrong");
  chk_illegal_pulse: assert property (
    ILLEGAL_O |=> !ILLEGAL_O)
    else $error("illegal flag longer than a pulse");
  chk_flush_refetch: assert property (
    MISPREDICT_O |-> ##[1:2] IFETCH_REQ_O)
    else $error("no refetch after flush");
  chk_flush_pulse: assert property (
    MISPREDICT_O |=> !MISPREDICT_O)
    else $error("flush flag longer than a pulse");
  chk_store_data: assert property (
    OPND_WE_O |-> $stable(OPND_WDATA_O))
    else $error("store data not held before commit");
  chk_issue_limit: assert property (
    ISSUE_CNT_O <= 2'h2)
    else $error("more than two issued");

  cov_store: cover property (OPND_WE_O);
  cov_illegal: cover property (ILLEGAL_O);
  cov_flush: cover property (MISPREDICT_O);
endmodule // pipe_ctrl_sva

bind pipe_ctrl pipe_ctrl_sva #(
  .BUS_RATIO(BUS_RATIO),
  .RESET_PC(RESET_PC)
) i_pipe_ctrl_sva (
  .MCLK_I, .RESET_I, .BUS_TICK_O, .IFETCH_REQ_O, .IFETCH_ADDR_O,
  .OPND_WE_O, .OPND_WDATA_O, .ISSUE_CNT_O, .MISPREDICT_O, .ILLEGAL_O,
  .EXC_VECTOR_O
);

//--- pipe_ctrl_test.sv
// Purpose: self-checking bench of pipe_ctrl with local memories
// Assumes: design defaults for bus ratio, reset and exception address
// Notes: each scenario reloads the program and resets the core
`timescale 1ns/100ps
`define CHK(n, e, a) compares++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
  end
module pipe_ctrl_test;
  import pipe_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cond = 1'b0;
  logic [31:0] base = 32'h0000_1000;
  logic [31:0] ropnd = 32'h0000_0000;
  logic [31:0] sdata = 32'h0000_0000;
  logic tick, ireq, rd, we, mis, ill, aalu, fold;
  logic [15:0] idata;
  logic [31:0] iaddr, raddr, rdata, waddr, wdata, acc, dq, dr, wa, wd;
  logic [1:0] icnt;
  logic [7:0] vec, vseen;
  int err_count = 0;
  int compares = 0;
  int cyc, n_tick, n_ill, n_mis, n_we, n_two, n_aalu, n_fold;
  int iss[$];
  logic [31:0] fa[$];

  pipe_ctrl i_pipe_ctrl (
    .MCLK_I(clk), .RESET_I(rst), .BUS_TICK_O(tick), .IFETCH_REQ_O(ireq),
    .IFETCH_ADDR_O(iaddr), .IFETCH_DATA_I(idata), .OPND_RD_O(rd),
    .OPND_RADDR_O(raddr), .OPND_RDATA_I(rdata), .OPND_WE_O(we),
    .OPND_WADDR_O(waddr), .OPND_WDATA_O(wdata), .BASE_ADDR_I(base),
    .REG_OPND_I(ropnd), .STORE_DATA_I(sdata), .COND_TRUE_I(cond),
    .ISSUE_CNT_O(icnt), .ISSUE_AALU_O(aalu), .BR_FOLD_O(fold),
    .MISPREDICT_O(mis),
    .ILLEGAL_O(ill), .EXC_VECTOR_O(vec), .ACC_O(acc), .DIV_Q_O(dq),
    .DIV_R_O(dr)
  );

  mem_model i_mem_model (
    .clk_i(clk), .ireq_i(ireq), .iaddr_i(iaddr), .idata_o(idata),
    .rd_i(rd), .raddr_i(raddr), .rdata_o(rdata), .we_i(we),
    .waddr_i(waddr), .wdata_i(wdata)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // event recorder; cleared while reset is held
  always @(posedge clk) begin
    if (rst) begin
      cyc = 0; n_tick = 0; n_ill = 0; n_mis = 0; n_we = 0;
      n_two = 0; n_aalu = 0; n_fold = 0;
      iss.delete();
      fa.delete();
    end else begin
      cyc++;
      if (tick) n_tick++;
      if (ireq) fa.push_back(iaddr);
      if (ill) begin n_ill++; vseen = vec; end
      if (mis) n_mis++;
      if (we) begin n_we++; wa = waddr; wd = wdata; end
      if (icnt != 2'h0) iss.push_back(cyc);
      if (icnt == 2'h2) n_two++;
      if (aalu) n_aalu++;
      if (fold) n_fold++;
    end
  end

  task automatic run(input logic [15:0] w0, w1, w2, w3, input int n);
    for (int k = 0; k < 1024; k++) i_mem_model.imem[k] = 16'h0000;
    i_mem_model.imem[0] = w0;
    i_mem_model.imem[1] = w1;
    i_mem_model.imem[2] = w2;
    i_mem_model.imem[16] = w3;
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_fetch;
    run(16'h0000, 16'h0000, 16'h0000, 16'h0000, 40);
    // first tick lands one cycle after a full divider turn
    `CHK("bus ticks", 40 / BUS_RATIO_DEF - 1, n_tick)
    `CHK("first fetch", RESET_PC_DEF, fa[0])
    `CHK("next fetch", RESET_PC_DEF + OPW_BYTES, fa[1])
    `CHK("no illegal", 0, n_ill)
    $display("fetch test done");
  endtask

  task automatic t_store;
    sdata <= 32'h5a5a_0f0f;
    run(16'h30f8, 16'h0000, 16'h0000, 16'h0000, 40);
    `CHK("store count", 1, n_we)
    `CHK("store addr", 32'h0000_0ff8, wa)
    `CHK("store data", 32'h5a5a_0f0f, wd)
    $display("store test done");
  endtask

  task automatic t_illegal;
    logic [15:0] bad [3] = '{16'hb000, 16'ha003, 16'hf0ff};
    foreach (bad[k]) begin
      run(bad[k], 16'h0000, 16'h0000, 16'h0000, 30);
      `CHK("illegal count", 1, n_ill)
      `CHK("vector", ILLEGAL_VEC, vseen)
    end
    $display("illegal test done");
  endtask

  task automatic t_branch;
    int total;
    total = 0;
    for (int c = 0; c < 2; c++) begin
      cond <= c[0];
      run(16'h4004, 16'h0000, 16'h0000, 16'h0000, 40);
      total += n_mis;
    end
    `CHK("one side mispredicts", 1, total)
    run(16'h601e, 16'h0000, 16'h0000, 16'h7000, 60);
    `CHK("call and return flush", 0, n_mis)
    `CHK("call target fetched", 1, int'(32'h0000_0020 inside {fa}))
    $display("branch test done");
  endtask

  task automatic t_arith;
    for (int k = 0; k < 16; k++) i_mem_model.dmem[k] = 32'h0000_0007;
    ropnd <= 32'd100;
    run(16'ha001, 16'ha002, 16'h0000, 16'h0000, 60);
    `CHK("quotient", 32'h0000_000e, dq)
    `CHK("remainder", 32'h0000_0002, dr)
    ropnd <= 32'd1000;
    run(16'ha000, 16'h0000, 16'h0000, 16'h0000, 60);
    `CHK("short quotient", 16'h008e, dq[15:0])
    `CHK("short remainder", 16'h0006, dr[15:0])
    run(16'h8000, 16'h9000, 16'h8000, 16'h0000, 60);
    `CHK("accumulator", 32'h0000_5208, acc)
    `CHK("short mac gap", 1, iss[1] - iss[0])
    `CHK("long mac gap", 3, iss[2] - iss[1])
    $display("arith test done");
  endtask

  // long multiply stalls decode so both decode registers fill behind it
  task automatic t_dual;
    run(16'h9000, 16'h2000, 16'h1000, 16'h0000, 30);
    `CHK("paired issue", 1, n_two)
    `CHK("address unit", 1, n_aalu)
    $display("dual issue test done");
  endtask

  // taken loop branch: one miss, then branch cache hits and folds
  task automatic t_fold;
    cond <= 1'b1;
    run(16'h9000, 16'h40fc, 16'h0000, 16'h0000, 60);
    `CHK("loop mispredicts", 1, n_mis)
    `CHK("branch folded", 1, int'(n_fold > 0))
    $display("fold test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // whole run is about 670 cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    t_fetch();
    t_store();
    t_illegal();
    t_branch();
    t_arith();
    t_dual();
    t_fold();
    print_verdict();
  end
endmodule // pipe_ctrl_test
